/* verilog/vsync_pkg.sv */
// package for the virtual-processor sync command engine
// assumes a single 40 MHz clock domain with synchronous active-high reset
`default_nettype none
package vsync_pkg;
  // ------------------------------------------------------------
  // command packet layout
  // ------------------------------------------------------------
  localparam int unsigned PACKET_BYTES = 32;
  localparam int unsigned PACKET_DWORDS = 4;
  localparam int unsigned DW_WIDTH = 64;
  localparam logic [7:0] OPC_VSYNC = 8'h25;
  localparam int unsigned OPC_LSB = 0;
  localparam int unsigned VPE_DW = 1;
  localparam int unsigned VPE_LSB = 32;
  localparam int unsigned VPE_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH = 48;
  localparam int unsigned RD_WIDTH = 32;
  localparam int unsigned ERR_WIDTH = 8;
  localparam int unsigned RD_ADDR_WIDTH = 5;
  // ------------------------------------------------------------
  // reset values and error codes
  // ------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] PTR_RESET = 48'h0;
  localparam logic [ERR_WIDTH-1:0] ERR_NONE = 8'h00;
  localparam logic [ERR_WIDTH-1:0] ERR_VPE_OOR = 8'h01;
  localparam logic [ERR_WIDTH-1:0] ERR_VPE_INVALID = 8'h02;
  localparam logic [ERR_WIDTH-1:0] ERR_BAD_OPCODE = 8'h03;
  localparam logic [ERR_WIDTH-1:0] ERR_RESERVED = 8'h04;
  // ------------------------------------------------------------
  // engine states, gray coded along fetch, check, lookup, wait
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_CHECK = 3'b011,
    ST_LOOKUP = 3'b010,
    ST_WAIT = 3'b110,
    ST_ADVANCE = 3'b111
  } eng_state_type;
  typedef enum logic [1:0] {
    MV_IDLE = 2'b00,
    MV_CLEAR = 2'b01,
    MV_RECHECK = 2'b11,
    MV_SWAP = 2'b10
  } move_state_type;
endpackage : vsync_pkg
`default_nettype wire

/* verilog/pending_mover.sv */
// moves one pending bit from a source to a destination owner
// assumes pending-state and clear handshake answers come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
module pending_mover (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request
  input wire logic mv_start,
  input wire logic mv_virtual,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] mv_src,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] mv_dst,
  input wire logic [31:0] mv_intid,
  output logic mv_busy,
  output logic mv_done,
  // pending query at the source
  input wire logic src_pending,
  // processor clear handshake
  output logic clr_req,
  output logic clr_virtual,
  input wire logic clr_ack,
  // local pending updates, clear then set in one cycle
  output logic pend_clr,
  output logic pend_set,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] pend_clr_base,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] pend_set_base,
  output logic [31:0] pend_intid
);
  import vsync_pkg::*;

  move_state_type mv_q;
  // ------------------------------------------------------------
  // move sequence
  // ------------------------------------------------------------
  // clear and set leave in the same cycle so the source cannot re-forward in between
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mv_q <= MV_IDLE;
      clr_req <= 1'b0;
      clr_virtual <= 1'b0;
      pend_clr <= 1'b0;
      pend_set <= 1'b0;
      mv_done <= 1'b0;
      pend_clr_base <= '0;
      pend_set_base <= '0;
      pend_intid <= '0;
    end else begin
      pend_clr <= 1'b0;
      pend_set <= 1'b0;
      mv_done <= 1'b0;
      case (mv_q)
        MV_IDLE: begin
          if (mv_start) begin
            pend_clr_base <= mv_src;
            pend_set_base <= mv_dst;
            pend_intid <= mv_intid;
            clr_virtual <= mv_virtual;
            if (src_pending) begin
              clr_req <= 1'b1; // RULE_15 RULE_16
              mv_q <= MV_CLEAR;
            end else begin
              mv_done <= 1'b1;
            end
          end
        end
        MV_CLEAR: begin
          if (clr_ack) begin
            clr_req <= 1'b0;
            mv_q <= MV_RECHECK;
          end
        end
        MV_RECHECK: begin
          if (src_pending) begin
            pend_clr <= 1'b1; // RULE_15 RULE_16
            pend_set <= 1'b1;
          end
          mv_q <= MV_SWAP;
        end
        MV_SWAP: begin
          mv_done <= 1'b1;
          mv_q <= MV_IDLE;
        end
        default: mv_q <= MV_IDLE;
      endcase
    end
  end

  assign mv_busy = (mv_q != MV_IDLE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_move_atomic: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
    pend_clr |-> pend_set) else $error("pending clear without matching set");
  a_clear_before: assert property (@(posedge clk_sys) disable iff (rst) // RULE_16
    $rose(pend_clr) |-> $past(mv_q) == MV_RECHECK) else $error("move skipped release");
endmodule : pending_mover
`default_nettype wire

/* verilog/vsync_engine.sv */
// command engine for the virtual-processor synchronisation command
// assumes a memory command queue answered by same-clock logic and a table reader
// What this block does
// [RULE_01] sync makes all outstanding work for the named processor observed before next command
// [RULE_02] opcode 0x25 in dword 0 low byte, id from dword 1 bit 32, rest zero
// [RULE_03] packets are 32 bytes: four 64-bit dwords located by index
// [RULE_04] id out of range: report if system errors supported, advance, nothing else
// [RULE_05] unmapped processor entry: report if enabled, advance, nothing else
// [RULE_06] after sync, earlier commands apply to later translation requests
// [RULE_07] valid sync reads target redistributor, waits for completion, then advances
// [RULE_08] each translation function behaves as if strictly atomic
// [RULE_09] accesses to one redistributor issue in generated order
// [RULE_10] redistributor writes need not wait for completion
// [RULE_11] table writes need not complete but later operations see them in order
// [RULE_12] memory writes appear per location in program order
// [RULE_13] translations after a function see its effects
// [RULE_14] a set pending bit stays until handled, though later functions may move it
// [RULE_15] physical move: release from processor, then clear source and set destination
// [RULE_16] virtual move: virtual clear handshake, then swap bits between pending tables
// [RULE_17] table and memory addresses are 48 bits
// [RULE_18] read pointer steps one packet and wraps at queue end
// [RULE_19] id out of range if above implemented width or configured table size
// [RULE_20] fetch only while read differs from write, stall during sync wait
`timescale 1ns/1ps
`default_nettype none
module vsync_engine (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // queue configuration and pointers
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] queue_base,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] queue_bytes,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] command_write_pointer,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] command_read_pointer,
  input wire logic system_error_support_flag,
  input wire logic [vsync_pkg::VPE_WIDTH-1:0] table_vpe_count,
  // command fetch, one dword per beat
  output logic cmd_rd_req,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] cmd_rd_addr,
  input wire logic cmd_rd_valid,
  input wire logic [vsync_pkg::DW_WIDTH-1:0] cmd_rd_data,
  // processor table lookup
  output logic vpe_lookup_req,
  output logic [vsync_pkg::VPE_WIDTH-1:0] virtual_pe_id,
  input wire logic vpe_lookup_valid,
  input wire logic vpe_entry_valid,
  input wire logic [vsync_pkg::RD_WIDTH-1:0] vpe_entry_rd,
  // completion wait toward redistributors
  output logic vcomp_req,
  output logic [vsync_pkg::RD_WIDTH-1:0] target_redistributor,
  input wire logic vcomp_done,
  input wire logic writes_outstanding,
  // error report
  output logic err_valid,
  output logic [vsync_pkg::ERR_WIDTH-1:0] err_code,
  // pending move requests from other translation functions
  input wire logic mv_start,
  input wire logic mv_virtual,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] mv_src,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] mv_dst,
  input wire logic [31:0] mv_intid,
  output logic mv_busy,
  output logic mv_done,
  input wire logic src_pending,
  output logic clr_req,
  output logic clr_virtual,
  input wire logic clr_ack,
  output logic pend_clr,
  output logic pend_set,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] pend_clr_base,
  output logic [vsync_pkg::ADDR_WIDTH-1:0] pend_set_base,
  output logic [31:0] pend_intid,
  // engine busy, translations held while high
  output logic translate_hold
);
  import vsync_pkg::*;

  localparam logic [ADDR_WIDTH-1:0] PKT_STEP = ADDR_WIDTH'(PACKET_BYTES);
  localparam logic [ADDR_WIDTH-1:0] DW_STEP = ADDR_WIDTH'(DW_WIDTH / 8);
  localparam logic [1:0] LAST_DW = 2'(PACKET_DWORDS - 1);

  eng_state_type st_q;
  logic [1:0] dw_idx_q;
  logic [DW_WIDTH-1:0] dw0_q;
  logic [DW_WIDTH-1:0] dw1_q;
  logic rsvd_bad_q;
  logic [ADDR_WIDTH-1:0] next_ptr_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // step one packet, wrap at the end of the queue
  function automatic logic [ADDR_WIDTH-1:0] step_ptr(input logic [ADDR_WIDTH-1:0] p,
                                                     input logic [ADDR_WIDTH-1:0] size);
    logic [ADDR_WIDTH-1:0] n;
    n = p + PKT_STEP;
    if (n >= size) begin
      n = '0;
    end
    return n;
  endfunction : step_ptr

  // out of range if above implemented width or at or above the configured count
  function automatic logic vpe_oor(input logic [DW_WIDTH-1:0] dw,
                                   input logic [VPE_WIDTH-1:0] cnt);
    return (dw[DW_WIDTH-1:VPE_LSB+VPE_WIDTH] != '0) ||
           (dw[VPE_LSB +: VPE_WIDTH] >= cnt);
  endfunction : vpe_oor

  // pointer is an offset into the queue
  assign next_ptr_d = step_ptr(command_read_pointer, queue_bytes); // RULE_18

  // ------------------------------------------------------------
  // command state machine
  // ------------------------------------------------------------
  // one command at a time makes each function atomic to outside observers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE; // RULE_08
      dw_idx_q <= 2'b00;
      command_read_pointer <= PTR_RESET;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (command_read_pointer != command_write_pointer) begin
            st_q <= ST_FETCH; // RULE_20
            dw_idx_q <= 2'b00;
          end
        end
        ST_FETCH: begin
          if (cmd_rd_valid) begin
            dw_idx_q <= dw_idx_q + 2'b01; // RULE_03
            if (dw_idx_q == LAST_DW) begin
              st_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (dw0_q[OPC_LSB +: 8] != OPC_VSYNC || rsvd_bad_q ||
              vpe_oor(dw1_q, table_vpe_count)) begin
            st_q <= ST_ADVANCE; // RULE_04 RULE_19
          end else begin
            st_q <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          if (vpe_lookup_valid) begin
            st_q <= vpe_entry_valid ? ST_WAIT : ST_ADVANCE; // RULE_05
          end
        end
        ST_WAIT: begin
          // table and redistributor writes may still be in flight until here
          if (vcomp_done && !writes_outstanding) begin
            st_q <= ST_ADVANCE; // RULE_01 RULE_07 RULE_10 RULE_11
          end
        end
        ST_ADVANCE: begin
          command_read_pointer <= next_ptr_d; // RULE_18
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // packet capture
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dw0_q <= '0;
      dw1_q <= '0;
      rsvd_bad_q <= 1'b0;
    end else if (st_q == ST_IDLE) begin
      rsvd_bad_q <= 1'b0;
    end else if (st_q == ST_FETCH && cmd_rd_valid) begin
      case (dw_idx_q)
        2'd0: begin
          dw0_q <= cmd_rd_data; // RULE_02
          if (cmd_rd_data[DW_WIDTH-1:8] != '0) begin
            rsvd_bad_q <= 1'b1;
          end
        end
        2'd1: begin
          dw1_q <= cmd_rd_data;
          if (cmd_rd_data[VPE_LSB-1:0] != '0) begin
            rsvd_bad_q <= 1'b1; // RULE_02
          end
        end
        default: begin
          if (cmd_rd_data != '0) begin
            rsvd_bad_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // lookup and completion outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target_redistributor <= '0;
    end else if (st_q == ST_LOOKUP && vpe_lookup_valid && vpe_entry_valid) begin
      target_redistributor <= vpe_entry_rd; // RULE_07
    end
  end

  // error code latched as the command ends in error
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_valid <= 1'b0;
      err_code <= ERR_NONE;
    end else begin
      err_valid <= 1'b0;
      if (st_q == ST_CHECK && system_error_support_flag) begin
        if (dw0_q[OPC_LSB +: 8] != OPC_VSYNC) begin
          err_valid <= 1'b1;
          err_code <= ERR_BAD_OPCODE;
        end else if (vpe_oor(dw1_q, table_vpe_count)) begin
          err_valid <= 1'b1; // RULE_04
          err_code <= ERR_VPE_OOR;
        end else if (rsvd_bad_q) begin
          err_valid <= 1'b1;
          err_code <= ERR_RESERVED;
        end
      end else if (st_q == ST_LOOKUP && vpe_lookup_valid && !vpe_entry_valid &&
                   system_error_support_flag) begin
        err_valid <= 1'b1; // RULE_05
        err_code <= ERR_VPE_INVALID;
      end
    end
  end

  assign cmd_rd_req = (st_q == ST_FETCH);
  assign cmd_rd_addr = queue_base + command_read_pointer + ADDR_WIDTH'(dw_idx_q) * DW_STEP; // RULE_17
  assign vpe_lookup_req = (st_q == ST_LOOKUP);
  assign virtual_pe_id = dw1_q[VPE_LSB +: VPE_WIDTH];
  assign vcomp_req = (st_q == ST_WAIT); // RULE_09
  // translations wait while a command is mid-flight, so they see its effects
  assign translate_hold = (st_q != ST_IDLE) || mv_busy; // RULE_06 RULE_13 RULE_12

  // ------------------------------------------------------------
  // pending move unit
  // ------------------------------------------------------------
  // pending bits only change through the mover, so they hold until handled
  pending_mover u_mover ( // RULE_14
    .clk_sys(clk_sys),
    .rst(rst),
    .mv_start(mv_start),
    .mv_virtual(mv_virtual),
    .mv_src(mv_src),
    .mv_dst(mv_dst),
    .mv_intid(mv_intid),
    .mv_busy(mv_busy),
    .mv_done(mv_done),
    .src_pending(src_pending),
    .clr_req(clr_req),
    .clr_virtual(clr_virtual),
    .clr_ack(clr_ack),
    .pend_clr(pend_clr),
    .pend_set(pend_set),
    .pend_clr_base(pend_clr_base),
    .pend_set_base(pend_set_base),
    .pend_intid(pend_intid)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_no_fetch_wait: assert property (@(posedge clk_sys) disable iff (rst) // RULE_20
    st_q == ST_WAIT |-> !cmd_rd_req) else $error("fetch during sync wait");
  a_wait_holds_ptr: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
    (st_q == ST_WAIT && !vcomp_done) |=> $stable(command_read_pointer))
    else $error("pointer moved before completion");
  a_ptr_step: assert property (@(posedge clk_sys) disable iff (rst) // RULE_18
    st_q == ST_ADVANCE |=> command_read_pointer == $past(next_ptr_d))
    else $error("pointer step wrong");
  a_ptr_in_queue: assert property (@(posedge clk_sys) disable iff (rst) // RULE_18
    $changed(command_read_pointer) |-> command_read_pointer < queue_bytes ||
    command_read_pointer == '0) else $error("pointer left queue");
  a_oor_skip: assert property (@(posedge clk_sys) disable iff (rst) // RULE_04
    (st_q == ST_CHECK && vpe_oor(dw1_q, table_vpe_count)) |=> st_q == ST_ADVANCE ##1 st_q == ST_IDLE)
    else $error("out of range not skipped");
  a_err_gated: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
    err_valid |-> $past(system_error_support_flag)) else $error("error without support");
  a_idle_empty: assert property (@(posedge clk_sys) disable iff (rst) // RULE_20
    (st_q == ST_IDLE && command_read_pointer == command_write_pointer) |=> st_q == ST_IDLE)
    else $error("fetch from empty queue");
  a_hold_busy: assert property (@(posedge clk_sys) disable iff (rst) // RULE_06
    st_q == ST_WAIT |-> translate_hold) else $error("translation not held");
  a_unmapped_skip: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
    (st_q == ST_LOOKUP && vpe_lookup_valid && !vpe_entry_valid) |=> st_q == ST_ADVANCE)
    else $error("unmapped processor not skipped");
  a_wait_release: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
    (st_q == ST_WAIT && vcomp_done && !writes_outstanding) |=> st_q == ST_ADVANCE)
    else $error("sync wait not released");
  a_target_taken: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
    (st_q == ST_LOOKUP && vpe_lookup_valid && vpe_entry_valid) |=>
    target_redistributor == $past(vpe_entry_rd)) else $error("target not taken");
endmodule : vsync_engine
`default_nettype wire

/* tb/queue_redist_model.sv */
// far-side model: command memory, processor table and redistributor completion
// assumes the bench fills mem directly and shares the engine clock
`timescale 1ns/1ps
`default_nettype none
module queue_redist_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pace: high makes answers come every other cycle and completion late
  input wire logic slow,
  // command memory
  input wire logic cmd_rd_req,
  input wire logic [vsync_pkg::ADDR_WIDTH-1:0] cmd_rd_addr,
  output logic cmd_rd_valid,
  output logic [vsync_pkg::DW_WIDTH-1:0] cmd_rd_data,
  // processor table
  input wire logic vpe_lookup_req,
  input wire logic [vsync_pkg::VPE_WIDTH-1:0] virtual_pe_id,
  output logic vpe_lookup_valid,
  output logic vpe_entry_valid,
  output logic [vsync_pkg::RD_WIDTH-1:0] vpe_entry_rd,
  // completion toward redistributors
  input wire logic vcomp_req,
  output logic vcomp_done
);
  import vsync_pkg::*;
  logic [DW_WIDTH-1:0] mem [0:31];
  logic pace_q;
  logic [3:0] wait_q;
  // ----------------------------------------------------------
  // pacing and completion delay
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) pace_q <= 1'b0;
    else pace_q <= ~pace_q;
  end
  // completion only after the request has stood a while, never at once
  always_ff @(posedge clk_sys) begin
    if (rst || !vcomp_req) wait_q <= 4'h0;
    else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
  end
  // one dword per beat, picked by address bits 7:3; idle data is inverted
  assign cmd_rd_valid = cmd_rd_req && (!slow || pace_q);
  assign cmd_rd_data = cmd_rd_valid ? mem[cmd_rd_addr[7:3]] : ~mem[cmd_rd_addr[7:3]];
  // processor 5 was never mapped; others map to a redistributor built from the id
  assign vpe_lookup_valid = vpe_lookup_req && (!slow || pace_q);
  assign vpe_entry_valid = vpe_lookup_valid ? (virtual_pe_id != 16'h0005) : pace_q;
  assign vpe_entry_rd = vpe_lookup_valid ? {16'h00c0, virtual_pe_id} : {32{pace_q}};
  assign vcomp_done = vcomp_req && (wait_q >= (slow ? 4'h9 : 4'h2));
endmodule : queue_redist_model
`default_nettype wire

/* tb/vsync_engine_tb.sv */
// bench for the sync command engine and its pending mover
// assumes queue at byte 0x40, three packets deep, eight processor entries
`timescale 1ns/1ps
`default_nettype none
module vsync_engine_tb;
  import vsync_pkg::*;
  logic clk_sys, rst, system_error_support_flag, slow;
  logic [ADDR_WIDTH-1:0] queue_base, queue_bytes, command_write_pointer, command_read_pointer;
  logic [ADDR_WIDTH-1:0] cmd_rd_addr, mv_src, mv_dst, pend_clr_base, pend_set_base, exp_ptr;
  logic [VPE_WIDTH-1:0] table_vpe_count, virtual_pe_id;
  logic cmd_rd_req, cmd_rd_valid, vpe_lookup_req, vpe_lookup_valid, vpe_entry_valid;
  logic [DW_WIDTH-1:0] cmd_rd_data;
  logic [RD_WIDTH-1:0] vpe_entry_rd, target_redistributor;
  logic vcomp_req, vcomp_done, writes_outstanding, err_valid, translate_hold;
  logic [ERR_WIDTH-1:0] err_code;
  logic mv_start, mv_virtual, mv_busy, mv_done, src_pending, clr_req, clr_virtual, clr_ack;
  logic pend_clr, pend_set;
  logic [31:0] mv_intid, pend_intid;
  int n_errors = 0;
  int cmp_count = 0;
  vsync_engine uut (.clk_sys(clk_sys), .rst(rst), .queue_base(queue_base),
    .queue_bytes(queue_bytes), .command_write_pointer(command_write_pointer),
    .command_read_pointer(command_read_pointer),
    .system_error_support_flag(system_error_support_flag), .table_vpe_count(table_vpe_count),
    .cmd_rd_req(cmd_rd_req), .cmd_rd_addr(cmd_rd_addr), .cmd_rd_valid(cmd_rd_valid),
    .cmd_rd_data(cmd_rd_data), .vpe_lookup_req(vpe_lookup_req), .virtual_pe_id(virtual_pe_id),
    .vpe_lookup_valid(vpe_lookup_valid), .vpe_entry_valid(vpe_entry_valid),
    .vpe_entry_rd(vpe_entry_rd), .vcomp_req(vcomp_req),
    .target_redistributor(target_redistributor), .vcomp_done(vcomp_done),
    .writes_outstanding(writes_outstanding), .err_valid(err_valid), .err_code(err_code),
    .mv_start(mv_start), .mv_virtual(mv_virtual), .mv_src(mv_src), .mv_dst(mv_dst),
    .mv_intid(mv_intid), .mv_busy(mv_busy), .mv_done(mv_done), .src_pending(src_pending),
    .clr_req(clr_req), .clr_virtual(clr_virtual), .clr_ack(clr_ack), .pend_clr(pend_clr),
    .pend_set(pend_set), .pend_clr_base(pend_clr_base), .pend_set_base(pend_set_base),
    .pend_intid(pend_intid), .translate_hold(translate_hold));
  queue_redist_model far (.clk_sys(clk_sys), .rst(rst), .slow(slow), .cmd_rd_req(cmd_rd_req),
    .cmd_rd_addr(cmd_rd_addr), .cmd_rd_valid(cmd_rd_valid), .cmd_rd_data(cmd_rd_data),
    .vpe_lookup_req(vpe_lookup_req), .virtual_pe_id(virtual_pe_id),
    .vpe_lookup_valid(vpe_lookup_valid), .vpe_entry_valid(vpe_entry_valid),
    .vpe_entry_rd(vpe_entry_rd), .vcomp_req(vcomp_req), .vcomp_done(vcomp_done));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // one packet through the queue; hold keeps writes outstanding to stall the sync wait
  task automatic exec(input logic [63:0] dw0, input logic [63:0] dw1, input logic hold,
                      input logic exp_err, input logic [7:0] exp_code, input logic exp_vc);
    logic [47:0] nxt;
    logic seen_err, seen_vc;
    logic [7:0] code;
    int idx, left;
    idx = int'((48'h40 + exp_ptr) >> 3);
    nxt = (exp_ptr + 48'h20 == 48'h60) ? 48'h0 : exp_ptr + 48'h20;
    seen_err = 0;
    seen_vc = 0;
    code = 8'h00;
    left = -1;
    far.mem[idx] = dw0;
    far.mem[idx+1] = dw1;
    far.mem[idx+2] = 64'h0;
    far.mem[idx+3] = 64'h0;
    @(posedge clk_sys);
    command_write_pointer <= nxt;
    writes_outstanding <= hold;
    if (hold) begin
      repeat (20) @(negedge clk_sys);
      chk("pointer held", command_read_pointer, exp_ptr);
      chk("completion asked", vcomp_req, 1'b1);
      chk("no fetch in wait", cmd_rd_req, 1'b0);
      chk("translations held", translate_hold, 1'b1);
      seen_vc = 1;
      @(posedge clk_sys);
      writes_outstanding <= 1'b0;
    end
    for (int i = 0; i < 300 && left != 0; i++) begin
      @(negedge clk_sys);
      if (err_valid === 1'b1) begin
        seen_err = 1;
        code = err_code;
      end
      if (vcomp_req === 1'b1) seen_vc = 1;
      if (left > 0) left--;
      else if (left < 0 && command_read_pointer === nxt) left = 3;
    end
    chk("read pointer", command_read_pointer, nxt);
    chk("error reported", seen_err, exp_err);
    chk("error code", code, exp_code);
    chk("completion used", seen_vc, exp_vc);
    if (exp_vc) begin
      chk("processor id", virtual_pe_id, dw1[47:32]);
      chk("target", target_redistributor, {16'h00c0, dw1[47:32]});
    end
    exp_ptr = nxt;
  endtask : exec
  // one pending move; pend0 is pending at start, pend1 after the processor lets go
  task automatic move(input logic virt, input logic pend0, input logic pend1);
    logic seen_req, seen_set, seen_done;
    seen_req = 0;
    seen_set = 0;
    seen_done = 0;
    @(posedge clk_sys);
    mv_start <= 1'b1;
    mv_virtual <= virt;
    src_pending <= pend0;
    mv_src <= 48'h1000 + virt;
    mv_dst <= 48'h2000 + pend1;
    mv_intid <= 32'h0000_2a00 + pend0;
    @(posedge clk_sys);
    mv_start <= 1'b0;
    if (pend0) begin
      for (int i = 0; i < 10 && !seen_req; i++) begin
        @(negedge clk_sys);
        if (clr_req === 1'b1) seen_req = 1;
      end
      repeat (3) @(negedge clk_sys);
      chk("clear held", clr_req, 1'b1);
      chk("clear kind", clr_virtual, virt);
      chk("busy hold", translate_hold, 1'b1);
      chk("mover busy", mv_busy, 1'b1);
      @(posedge clk_sys);
      clr_ack <= 1'b1;
      src_pending <= pend1;
      @(posedge clk_sys);
      clr_ack <= 1'b0;
    end
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      if (pend_clr !== pend_set) chk("clear with set", pend_clr, pend_set);
      if (pend_set === 1'b1) begin
        seen_set = 1;
        chk("source", pend_clr_base, 48'h1000 + virt);
        chk("dest", pend_set_base, 48'h2000 + pend1);
        chk("intid", pend_intid, 32'h0000_2a00 + pend0);
      end
      if (clr_req === 1'b1 && !pend0) seen_req = 1;
      if (mv_done === 1'b1) seen_done = 1;
    end
    chk("handshake", seen_req, pend0);
    chk("moved", seen_set, pend0 & pend1);
    chk("done", seen_done, 1'b1);
    chk("mover idle", mv_busy, 1'b0);
  endtask : move
  // ----------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    queue_base = 48'h40;
    queue_bytes = 48'h60;
    table_vpe_count = 16'h0008;
    command_write_pointer = 48'h0;
    system_error_support_flag = 1'b1;
    slow = 1'b0;
    writes_outstanding = 1'b0;
    {mv_start, mv_virtual, src_pending, clr_ack} = 4'h0;
    {mv_src, mv_dst, mv_intid} = '0;
    exp_ptr = 48'h0;
    for (int i = 0; i < 32; i++) far.mem[i] = 64'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("reset pointer", command_read_pointer, 48'h0);
    chk("reset error", err_valid, 1'b0);
    exec(64'h25, 64'h0003_0000_0000, 1'b1, 1'b0, ERR_NONE, 1'b1);
    exec(64'h25, 64'h0008_0000_0000, 1'b0, 1'b1, ERR_VPE_OOR, 1'b0);
    exec(64'h25, 64'h0005_0000_0000, 1'b0, 1'b1, ERR_VPE_INVALID, 1'b0);
    exec(64'h26, 64'h0002_0000_0000, 1'b0, 1'b1, ERR_BAD_OPCODE, 1'b0);
    exec(64'h0100_0025, 64'h0002_0000_0000, 1'b0, 1'b1, ERR_RESERVED, 1'b0);
    @(posedge clk_sys);
    system_error_support_flag <= 1'b0;
    exec(64'h25, 64'h0008_0000_0000, 1'b0, 1'b0, ERR_NONE, 1'b0);
    @(posedge clk_sys);
    slow <= 1'b1;
    exec(64'h25, 64'h0007_0000_0000, 1'b0, 1'b0, ERR_NONE, 1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    command_write_pointer <= 48'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("pointer after reset", command_read_pointer, 48'h0);
    move(1'b0, 1'b1, 1'b1);
    move(1'b1, 1'b1, 1'b1);
    move(1'b1, 1'b1, 1'b0);
    move(1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : vsync_engine_tb
`default_nettype wire
